// [design/epe_pkg.sv]
// constants and types for the eeprom program/erase control block
package epe_pkg;
   // register byte addresses on the cpu bus
   localparam logic [15:0] ADDR_DIVH_BAK1 = 16'hFE10;
   localparam logic [15:0] ADDR_DIVL_BAK1 = 16'hFE11;
   localparam logic [15:0] ADDR_DIVH      = 16'hFE1A;
   localparam logic [15:0] ADDR_DIVL      = 16'hFE1B;
   localparam logic [15:0] ADDR_NVR       = 16'hFE1C;
   localparam logic [15:0] ADDR_CR        = 16'hFE1D;
   localparam logic [15:0] ADDR_ACR       = 16'hFE1F;
   localparam logic [15:0] ADDR_DIVH_BAK2 = 16'hFF70;
   localparam logic [15:0] ADDR_DIVL_BAK2 = 16'hFF71;
   // array window: 512 bytes in four blocks of 128
   localparam logic [15:0] ARRAY_BASE = 16'h0800;
   localparam logic [15:0] ARRAY_END  = 16'h0A00;
   localparam int          ARRAY_AW   = 9;
   localparam int          ARRAY_DEPTH = 512;
   localparam logic [8:0]  IDX_LAST   = 9'h1FF;
   localparam logic [6:0]  BLK_FIRST  = 7'h00;
   localparam logic [6:0]  BLK_LAST   = 7'h7F;
   localparam logic [7:0]  ERASED_BYTE = 8'hFF;
   // control register fields
   localparam int CR_PGM    = 0;
   localparam int CR_LAT    = 1;
   localparam int CR_RAS_LO = 2;
   localparam int CR_RAS_HI = 3;
   localparam int CR_AUTO   = 4;
   localparam logic [7:0] CR_MASK  = 8'h1F;
   localparam logic [7:0] CR_RESET = 8'h00;
   // configuration register fields
   localparam int ACR_SEC = 4;
   localparam logic [7:0] ACR_RESET = 8'hF0;
   // program or erase size select codes {hi, lo}
   localparam logic [1:0] OP_PROG  = 2'h0;
   localparam logic [1:0] OP_BYTE  = 2'h1;
   localparam logic [1:0] OP_BLOCK = 2'h2;
   localparam logic [1:0] OP_ALL   = 2'h3;
   // power-up contents of the nonvolatile copies
   localparam logic [7:0] NVR_INIT  = 8'hF0;
   localparam logic [7:0] DIVH_INIT = 8'h00;
   localparam logic [7:0] DIVL_INIT = 8'h40;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } epe_bus_t;

   typedef enum logic [4:0] {
      ST_IDLE  = 5'b00001,
      ST_READ  = 5'b00010,
      ST_APPLY = 5'b00100,
      ST_SWEEP = 5'b01000,
      ST_HOLD  = 5'b10000
   } epe_state_t;
endpackage

// [design/epe_mem.sv]
// byte-wide array storage with registered read data
`timescale 1ns/1ps
module epe_mem import epe_pkg::*; (
   input  logic                sys_clk,
   input  logic                ce,
   input  logic                we,
   input  logic [ARRAY_AW-1:0] addr,
   input  logic [7:0]          wdata,
   output logic [7:0]          rdata_q
);
   logic [7:0] mem [ARRAY_DEPTH];

   // one read per enabled cycle, plus a write when we is set
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         rdata_q <= mem[addr];
      end
   end
endmodule // epe_mem

// [design/epe_ctrl.sv]
// program/erase control for one on-chip eeprom array
`timescale 1ns/1ps
module epe_ctrl import epe_pkg::*; (
   input  logic       sys_clk,
   input  logic       rst,
   input  logic       ce,
   input  epe_bus_t   bus_req,
   output logic [7:0] rd_data,
   output logic       rd_valid,
   output logic       hv_on
);
   // is an address inside the array window
   function automatic logic in_array(input logic [15:0] a);
      return (a >= ARRAY_BASE) && (a < ARRAY_END);
   endfunction

   // is the block holding an array index protected
   function automatic logic blk_prot(input logic [ARRAY_AW-1:0] i,
                                     input logic [3:0] p);
      return p[i[ARRAY_AW-1 -: 2]];
   endfunction

   logic [7:0]          cr_q, cr_d;
   logic [7:0]          acr_q;
   logic [7:0]          divh_q, divl_q;
   logic [7:0]          nvr_q      = NVR_INIT;
   logic [7:0]          divh_bk1_q = DIVH_INIT;
   logic [7:0]          divl_bk1_q = DIVL_INIT;
   logic [7:0]          divh_bk2_q = DIVH_INIT;
   logic [7:0]          divl_bk2_q = DIVL_INIT;
   logic                load_q;
   logic [15:0]         lat_addr_q;
   logic [7:0]          lat_data_q;
   logic                lat_valid_q;
   epe_state_t          st_q, st_d;
   logic [15:0]         tmr_q;
   logic [ARRAY_AW-1:0] swp_q, swp_end_q;
   logic                rd_pend_q, rd_mem_q;
   logic [7:0]          rd_reg_q;
   logic [7:0]          mem_rdata;

   // bus decode
   wire        wr     = ce && bus_req.wr;
   wire        rd     = ce && bus_req.rd;
   wire [7:0]  w      = bus_req.wdata;
   wire        cr_wr  = wr && (bus_req.addr == ADDR_CR);
   wire        acr_wr = wr && (bus_req.addr == ADDR_ACR);
   wire        arr_hit = in_array(bus_req.addr);
   wire        nvr_hit = (bus_req.addr == ADDR_NVR);
   wire        lat_hit = arr_hit || nvr_hit;

   // control fields
   wire        pgm  = cr_q[CR_PGM];
   wire        cap  = cr_q[CR_LAT];
   wire        auto_on = cr_q[CR_AUTO];
   wire [1:0]  op   = {cr_q[CR_RAS_HI], cr_q[CR_RAS_LO]};
   wire        op_sweep = (op == OP_BLOCK) || (op == OP_ALL);

   // latched target
   wire [ARRAY_AW-1:0] lat_idx = lat_addr_q[ARRAY_AW-1:0];
   wire        lat_in_arr = in_array(lat_addr_q);
   wire        lat_is_nvr = (lat_addr_q == ADDR_NVR);
   wire        lat_prot   = blk_prot(lat_idx, acr_q[3:0]);
   wire        pgm_set_ok = cap && lat_valid_q;
   wire        auto_done = (st_q == ST_HOLD) && auto_on && (tmr_q == 16'h0000);

   // control register next value
   always_comb begin
      cr_d = cr_q;
      if (cr_wr) begin
         cr_d = w & CR_MASK;
         if (w[CR_PGM] && !pgm && !pgm_set_ok) begin
            cr_d[CR_PGM] = 1'b0;
         end
         if (pgm && !w[CR_LAT]) begin
            cr_d[CR_LAT] = 1'b1;
         end
      end
      if (auto_done) begin
         cr_d[CR_PGM] = 1'b0;
      end
   end

   wire pgm_rise = !pgm && cr_d[CR_PGM];
   wire pgm_fall = pgm && !cr_d[CR_PGM];

   // cycle sequencer
   always_comb begin
      st_d = st_q;
      case (st_q)
         ST_IDLE:  if (pgm_rise) st_d = ST_READ;
         ST_READ:  st_d = ST_APPLY;
         ST_APPLY: st_d = op_sweep ? ST_SWEEP : ST_HOLD;
         ST_SWEEP: if (swp_q == swp_end_q) st_d = ST_HOLD;
         ST_HOLD:  st_d = ST_HOLD;
         default:  st_d = ST_IDLE;
      endcase
      if (pgm_fall) begin
         st_d = ST_IDLE;
      end
   end

   // array port: cpu reads when idle, sequencer otherwise
   wire [ARRAY_AW-1:0] mem_addr = (st_q == ST_SWEEP) ? swp_q :
                                  (st_q == ST_IDLE) ?
                                  bus_req.addr[ARRAY_AW-1:0] : lat_idx;
   wire apply_we = (st_q == ST_APPLY) && !op_sweep &&
                   lat_in_arr && !lat_prot;
   wire sweep_we = (st_q == ST_SWEEP) &&
                   !blk_prot(swp_q, acr_q[3:0]);
   wire mem_we = ce && (apply_we || sweep_we);
   wire [7:0] mem_wdata = (op == OP_PROG) ? (mem_rdata & lat_data_q)
                                          : ERASED_BYTE;

   epe_mem u_mem (
      .sys_clk (sys_clk),
      .ce      (ce),
      .we      (mem_we),
      .addr    (mem_addr),
      .wdata   (mem_wdata),
      .rdata_q (mem_rdata)
   );

   // register read mux; array under capture returns latched data
   wire [7:0] reg_rdata =
      (arr_hit && cap)                   ? lat_data_q :
      nvr_hit                            ? nvr_q      :
      (bus_req.addr == ADDR_CR)          ? cr_q       :
      (bus_req.addr == ADDR_ACR)         ? acr_q      :
      (bus_req.addr == ADDR_DIVH)        ? divh_q     :
      (bus_req.addr == ADDR_DIVL)        ? divl_q     :
      (bus_req.addr == ADDR_DIVH_BAK1)   ? divh_bk1_q :
      (bus_req.addr == ADDR_DIVL_BAK1)   ? divl_bk1_q :
      (bus_req.addr == ADDR_DIVH_BAK2)   ? divh_bk2_q :
      (bus_req.addr == ADDR_DIVL_BAK2)   ? divl_bk2_q : 8'h00;

   // control, state and output flops
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         cr_q     <= CR_RESET;
         st_q     <= ST_IDLE;
         hv_on    <= 1'b0;
         rd_valid <= 1'b0;
         rd_data  <= 8'h00;
      end else if (ce) begin
         cr_q     <= cr_d;
         st_q     <= st_d;
         // pump gated by capture and latch
         hv_on    <= cr_d[CR_PGM] && cr_d[CR_LAT] && lat_valid_q;
         rd_valid <= rd_pend_q;
         rd_data  <= rd_mem_q ? mem_rdata : rd_reg_q;
      end
   end

   // read pipeline
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rd_pend_q <= 1'b0;
         rd_mem_q  <= 1'b0;
         rd_reg_q  <= 8'h00;
      end else if (ce) begin
         rd_pend_q <= rd;
         rd_mem_q  <= rd && arr_hit && !cap;
         rd_reg_q  <= reg_rdata;
      end
   end

   // address and data capture
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         lat_addr_q  <= 16'h0000;
         lat_data_q  <= ERASED_BYTE;
         lat_valid_q <= 1'b0;
      end else if (ce && cap && !pgm) begin
         if (wr && lat_hit) begin
            lat_addr_q  <= bus_req.addr;
            lat_data_q  <= w;
            lat_valid_q <= 1'b1;
         end else if (rd && arr_hit) begin
            lat_addr_q  <= bus_req.addr;
            lat_valid_q <= 1'b1;
         end
      end
   end

   // cycle timer and erase sweep
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         tmr_q     <= 16'h0000;
         swp_q     <= '0;
         swp_end_q <= '0;
      end else if (ce) begin
         if (pgm_rise) begin
            tmr_q <= {divh_q, divl_q};
         end else if (tmr_q != 16'h0000) begin
            tmr_q <= tmr_q - 16'h0001;
         end
         if (st_q == ST_APPLY) begin
            swp_q     <= (op == OP_ALL) ? '0
                         : {lat_idx[ARRAY_AW-1 -: 2], BLK_FIRST};
            swp_end_q <= (op == OP_ALL) ? IDX_LAST
                         : {lat_idx[ARRAY_AW-1 -: 2], BLK_LAST};
         end else if (st_q == ST_SWEEP) begin
            swp_q <= swp_q + 9'h001;
         end
      end
   end

   // configuration and divider registers
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         acr_q  <= ACR_RESET;
         divh_q <= DIVH_INIT;
         divl_q <= DIVL_INIT;
         load_q <= 1'b1;
      end else if (ce) begin
         load_q <= 1'b0;
         if (load_q) begin
            acr_q  <= nvr_q;
            divh_q <= divh_bk1_q;
            divl_q <= divl_bk1_q;
         end else begin
            if (acr_wr) begin
               acr_q <= {w[7:5], acr_q[ACR_SEC] & w[ACR_SEC], acr_q[3:0]};
            end
            if (wr && bus_req.addr == ADDR_DIVH) divh_q <= w;
            if (wr && bus_req.addr == ADDR_DIVL) divl_q <= w;
         end
      end
   end

   // nonvolatile copies, untouched by reset
   always_ff @(posedge sys_clk) begin
      if (ce) begin
         if (wr && bus_req.addr == ADDR_DIVH_BAK1) divh_bk1_q <= w;
         if (wr && bus_req.addr == ADDR_DIVL_BAK1) divl_bk1_q <= w;
         if (wr && bus_req.addr == ADDR_DIVH_BAK2) divh_bk2_q <= w;
         if (wr && bus_req.addr == ADDR_DIVL_BAK2) divl_bk2_q <= w;
         if (st_q == ST_APPLY && lat_is_nvr) begin
            if (op == OP_PROG) begin
               nvr_q <= nvr_q & lat_data_q;
            end else if (op == OP_BYTE && acr_q[ACR_SEC]) begin
               nvr_q <= ERASED_BYTE;
            end
         end
      end
   end

   // checks on the guarded behaviour
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst || !ce);

   sequence s_manual_clear;
      cr_wr && pgm && !auto_on && !w[CR_PGM];
   endsequence

   sequence s_both_clear;
      cr_wr && pgm && !w[CR_PGM] && !w[CR_LAT];
   endsequence

   a_auto_clear: assert property (
      auto_done |=> !cr_q[CR_PGM] && st_q == ST_IDLE && !hv_on)
      else $error("auto mode did not end the cycle");

   a_hv_gate: assert property (
      hv_on |-> cr_q[CR_PGM] && cr_q[CR_LAT] && lat_valid_q)
      else $error("high voltage on without capture and latch");

   a_pgm_reset: assert property (
      $past(rst) |-> !cr_q[CR_PGM] && !hv_on)
      else $error("enable bit set after reset");

   a_both_clear: assert property (
      s_both_clear |=> cr_q[CR_LAT] && !cr_q[CR_PGM])
      else $error("single write cleared capture too");

   a_acr_load: assert property (
      load_q |=> acr_q == $past(nvr_q) && divh_q == $past(divh_bk1_q))
      else $error("config not loaded from backup");

   a_spare_bits: assert property (
      acr_wr && !load_q |=> (acr_q & 8'hE0) == ($past(w) & 8'hE0))
      else $error("spare config bits not stored");

   a_sec_once: assert property (
      !acr_q[ACR_SEC] && !load_q |=> !acr_q[ACR_SEC])
      else $error("security returned to disabled");

   a_prog_clear: assert property (
      mem_we && op == OP_PROG |-> (mem_wdata & ~mem_rdata) == 8'h00
         && (mem_wdata | lat_data_q) == lat_data_q)
      else $error("programming set a bit to one");

   a_erase_ones: assert property (
      mem_we && op != OP_PROG |-> mem_wdata == ERASED_BYTE)
      else $error("erase did not write all ones");

   a_prot_block: assert property (
      mem_we |-> !blk_prot(mem_addr, acr_q[3:0]))
      else $error("protected block altered");

   a_pgm_refuse: assert property (
      cr_wr && !pgm && !pgm_set_ok |=> !cr_q[CR_PGM] ##1 !hv_on)
      else $error("enable accepted without valid latch");

   a_latch_upd: assert property (
      wr && lat_hit && cap && !pgm |=>
         lat_addr_q == $past(bus_req.addr) && lat_valid_q)
      else $error("latch not replaced by new write");

   a_manual_end: assert property (
      s_manual_clear |=> st_q == ST_IDLE && !hv_on)
      else $error("manual clear did not end the cycle");

   a_timer_load: assert property (
      st_q == ST_IDLE && pgm_rise |=>
         tmr_q == {$past(divh_q), $past(divl_q)})
      else $error("timer not loaded from divider");
endmodule // epe_ctrl

// [sim/epe_ctrl_tb.sv]
// self-checking bench for the eeprom program/erase control block
`timescale 1ns/1ps
module epe_ctrl_tb import epe_pkg::*;;
   localparam logic [7:0] DIV = 8'h08;
   logic        sys_clk;
   logic        rst = 1'b1;
   logic        ce = 1'b1;
   epe_bus_t    req = '0;
   logic [7:0]  rd_data;
   logic        rd_valid;
   logic        hv_on;
   int          fails = 0;
   int          num_checks = 0;
   int          cyc = 0;
   int          hv_len;
   logic [31:0] seed = 32'd92802;
   logic [7:0]  exp_mem [ARRAY_DEPTH];

   epe_ctrl DUT (.sys_clk(sys_clk), .rst(rst), .ce(ce), .bus_req(req),
      .rd_data(rd_data), .rd_valid(rd_valid), .hv_on(hv_on));

   // free-running clock
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end

   // hang guard
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         fails = fails + 1;
         results();
      end
   end

   // xorshift source
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // control byte for an operation with capture set
   function automatic logic [7:0] ctl(input logic [1:0] op, input logic au);
      return {3'h0, au, op, 2'b10};
   endfunction

   task automatic chk(input string nm, input logic [7:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge sys_clk);
      req.wr <= 1'b0;
   endtask

   // read answer stands in the cycle after the first edge past the take
   task automatic rc(input logic [15:0] a, input logic [7:0] e,
                     input string nm);
      @(posedge sys_clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge sys_clk);
      req.rd <= 1'b0;
      @(posedge sys_clk);
      #1;
      chk("rd_valid", {7'h0, rd_valid}, 8'h01);
      chk(nm, rd_data, e);
   endtask

   task automatic hv_wait(input logic lvl, input int lim, output int n);
      n = 0;
      while (hv_on !== lvl && n < lim) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
   endtask

   // one auto-terminated program or erase sequence
   task automatic pe(input logic [1:0] op, input logic [15:0] a,
                     input logic [7:0] d, input logic ck);
      logic [7:0] c;
      int n;
      c = ctl(op, 1'b1);
      // mode and capture set before target write
      wr(ADDR_CR, c);
      wr(a, d);
      #1;
      chk("hv_early", {7'h0, hv_on}, 8'h00);
      wr(ADDR_CR, c | 8'h01);
      hv_wait(1'b1, 4, n);
      chk("hv_start", {7'h0, hv_on}, 8'h01);
      hv_wait(1'b0, 2000, n);
      hv_len = n;
      chk("hv_end", {7'h0, hv_on}, 8'h00);
      if (ck) rc(ADDR_CR, c, "cr_auto");
      wr(ADDR_CR, 8'h00);
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      #1;
      chk("hv_rst", {7'h0, hv_on}, 8'h00);
      @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // main sequence
   initial begin
      int n;
      logic [15:0] a;
      logic [7:0] d;
      do_reset();
      rc(ADDR_ACR, NVR_INIT, "acr_load");
      rc(16'hFE12, 8'h00, "unmapped");
      wr(ADDR_DIVH, 8'h00);
      wr(ADDR_DIVL, DIV);
      rc(ADDR_DIVL, DIV, "divl");
      // clock enable low: a write must be ignored
      @(posedge sys_clk);
      ce <= 1'b0;
      wr(ADDR_DIVL, 8'h55);
      @(posedge sys_clk);
      ce <= 1'b1;
      rc(ADDR_DIVL, DIV, "ce_freeze");
      wr(ADDR_CR, 8'h01);
      rc(ADDR_CR, 8'h00, "no_capture");
      wr(ADDR_CR, 8'h02);
      wr(ADDR_CR, 8'h03);
      rc(ADDR_CR, 8'h02, "no_address");
      wr(ADDR_CR, 8'h00);
      $display("test refuse done");
      pe(OP_ALL, ARRAY_BASE, 8'h00, 1'b1);
      for (int j = 0; j < ARRAY_DEPTH; j++) exp_mem[j] = ERASED_BYTE;
      for (int i = 0; i < 6; i++) begin
         // each erased byte programmed once only
         n = {i[2:0], 6'(rnd())};
         a = ARRAY_BASE + 16'(n);
         rc(a, ERASED_BYTE, "erased");
         d = 8'(rnd());
         pe(OP_PROG, a, d, 1'b1);
         if (i == 0) chk("hv_len", 8'(hv_len >= 8 && hv_len <= 16), 8'h01);
         exp_mem[n] = exp_mem[n] & d;
         rc(a, exp_mem[n], "prog");
      end
      pe(OP_BYTE, a, 8'h00, 1'b1);
      rc(a, ERASED_BYTE, "byte_erase");
      $display("test program done");
      a = ARRAY_BASE + 16'(IDX_LAST);
      for (int k = 0; k < 4; k++) begin
         d = ~(8'h01 << k);
         pe(OP_PROG, a, d, 1'b1);
         rc(a, 8'hFF << (k + 1), "bitwise");
      end
      pe(OP_BLOCK, ARRAY_BASE, 8'h00, 1'b1);
      rc(ARRAY_BASE + 16'h0040, ERASED_BYTE, "blk_in");
      rc(ARRAY_BASE + 16'h0080, exp_mem[128], "blk_out");
      $display("test erase done");
      wr(ADDR_CR, 8'h02);
      wr(ARRAY_BASE + 16'h0002, 8'h5A);
      wr(ARRAY_BASE + 16'h0003, 8'hA5);
      rc(ARRAY_BASE + 16'h0002, 8'hA5, "latched");
      wr(ADDR_CR, 8'h00);
      wr(ADDR_CR, 8'h02);
      wr(a, 8'hEF);
      wr(ADDR_CR, 8'h03);
      hv_wait(1'b1, 4, n);
      chk("hv_on", {7'h0, hv_on}, 8'h01);
      repeat (20) @(posedge sys_clk);
      wr(ADDR_CR, 8'h00);
      hv_wait(1'b0, 8, n);
      chk("hv_off", {7'h0, hv_on}, 8'h00);
      rc(ADDR_CR, 8'h02, "both_clear");
      wr(ADDR_CR, 8'h00);
      rc(a, 8'hE0, "manual");
      $display("test manual done");
      pe(OP_BYTE, ADDR_NVR, 8'h00, 1'b1);
      rc(ADDR_NVR, ERASED_BYTE, "nvr_erase");
      do_reset();
      rc(ADDR_ACR, 8'hFF, "acr_reload");
      pe(OP_PROG, ARRAY_BASE, 8'h00, 1'b0);
      rc(ARRAY_BASE, ERASED_BYTE, "protected");
      $display("test protect done");
      d = 8'(rnd());
      wr(ADDR_ACR, {d[7:5], 5'h10});
      rc(ADDR_ACR, {d[7:5], 5'h1F}, "spare");
      wr(ADDR_ACR, 8'hA0);
      rc(ADDR_ACR, 8'hAF, "lock");
      wr(ADDR_ACR, 8'hF0);
      rc(ADDR_ACR, 8'hEF, "stay_locked");
      $display("test security done");
      results();
   end
endmodule // epe_ctrl_tb
